// *** inc/dpfc_pkg.sv ***
// Constants for the data pointer and frame control block.
// Assumes an APB slave with 32-bit data and byte addresses on paddr.
package dpfc_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] DPFC_OFS_FRAME_OFFSET = 8'h00;
  localparam logic [7:0] DPFC_OFS_POINTER_CONTROL = 8'h04;
  localparam logic [7:0] DPFC_OFS_GENERAL_WORD = 8'h08;
  localparam logic [7:0] DPFC_OFS_GENERAL_LOW_BYTE = 8'h0C;
  localparam logic [7:0] DPFC_OFS_GENERAL_HIGH_BYTE = 8'h10;
  localparam logic [7:0] DPFC_OFS_GENERAL_SWAPPED = 8'h14;

  // ==========================================================
  // Reset values
  localparam logic [7:0] DPFC_RST_FRAME_OFFSET = 8'h00;
  localparam logic [15:0] DPFC_RST_CTRL_BYTE_VARIANT = 16'h0000;
  localparam logic [15:0] DPFC_RST_CTRL_WORD_VARIANT = 16'h001C;
  localparam logic [7:0] DPFC_RST_BYTE = 8'h00;

  // ==========================================================
  // Pointer control field layout
  localparam int DPFC_SEL_LSB = 0;
  localparam int DPFC_SEL_MSB = 1;
  localparam int DPFC_WBS_LSB = 2;
  localparam int DPFC_WBS_MSB = 4;

  // Source pointer select codes
  localparam logic [1:0] DPFC_SEL_DP_ZERO = 2'h0;
  localparam logic [1:0] DPFC_SEL_DP_ONE = 2'h1;
  localparam logic [1:0] DPFC_SEL_FRAME = 2'h2;
  localparam logic [1:0] DPFC_SEL_RESERVED = 2'h3;

  localparam logic [7:0] DPFC_OFFS_STEP = 8'h01;
  localparam logic [7:0] DPFC_BYTE_ZERO = 8'h00;
  localparam logic [31:0] DPFC_WORD_ZERO = 32'h0000_0000;

endpackage : dpfc_pkg

// *** rtl/dpfc_byte_reg.sv ***
// One byte of storage with a synchronous clear and a write strobe.
// Assumes the write strobe and data are synchronous to clk.
`timescale 1ns/10ps
module dpfc_byte_reg
  import dpfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);

  // ==========================================================
  // Storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= DPFC_RST_BYTE;
    end else if (we) begin
      q <= wdata;
    end
  end

endmodule : dpfc_byte_reg

// *** rtl/dpfc_top.sv ***
// Frame offset, pointer control and general word registers on APB.
// Assumes the core drives its pointer strobes synchronous to clk and
// holds the frame base register outside this block.
//
// Notes on behaviour
// - Frame offset: 8-bit, cleared on reset
// - Frame pointer equals base plus offset, unsigned
// - Read access: use offset, then step it
// - Write access: step offset, then use it
// - Offset carry never touches the frame base
// - Control reset: zero, or word bits set
// - Select 00 dp0, 01 dp1, 1x frame
// - Reset select not active until written
// - Pointer writes retarget the source select field
// - Control bit 2: data pointer zero word mode
// - Control bit 3: data pointer one word mode
// - Control bit 4: frame pointer word mode
// - Control bits 15:5 read as zero
// - General word: 16-bit, cleared on reset
// - Byte views plus a byte-swapped view
// - Low-byte write keeps the high byte
// - High-byte write keeps the low byte
// - Swapped view is read-only, bytes exchanged
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module dpfc_top
  import dpfc_pkg::*;
#(
  parameter bit WORD_RESET_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [15:0] frame_base,
  input wire logic dp_zero_written,
  input wire logic dp_one_written,
  input wire logic frame_base_written,
  input wire logic fp_access,
  input wire logic fp_access_write,
  input wire logic fp_modify,
  input wire logic fp_decrement,
  output logic [15:0] frame_pointer,
  output logic [15:0] fp_access_addr,
  output logic fp_access_valid,
  output logic [1:0] source_pointer_select,
  output logic source_valid,
  output logic word_byte_select_zero,
  output logic word_byte_select_one,
  output logic word_byte_select_frame,
  output logic [7:0] frame_offset
);

  localparam logic [15:0] CTRL_RST =
    WORD_RESET_VARIANT ? DPFC_RST_CTRL_WORD_VARIANT : DPFC_RST_CTRL_BYTE_VARIANT;

  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [7:0] offs_q, offs_d, offs_stepped;
  logic [1:0] sel_q, sel_d, src_q;
  logic [2:0] wbs_q;
  logic active_q, active_d;
  logic [15:0] fp_q, fp_addr_q;
  logic fp_valid_q;
  logic [7:0] gen_low, gen_high;
  logic [15:0] gen_word;
  logic setup, access, wr_en, mapped, rd_only;
  logic wr_offs, wr_ctrl, wr_word, wr_low, wr_high;
  logic [31:0] rd_data;

  // ==========================================================
  // APB slave: one wait-free answer registered at the setup edge
  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign wr_en = access && pwrite && !pslverr_q;
  assign wr_offs = wr_en && (paddr == DPFC_OFS_FRAME_OFFSET) && pstrb[0];
  assign wr_ctrl = wr_en && (paddr == DPFC_OFS_POINTER_CONTROL) && pstrb[0];
  assign wr_word = wr_en && (paddr == DPFC_OFS_GENERAL_WORD);
  assign wr_low = wr_en && (paddr == DPFC_OFS_GENERAL_LOW_BYTE) && pstrb[0];
  assign wr_high = wr_en && (paddr == DPFC_OFS_GENERAL_HIGH_BYTE) && pstrb[0];
  assign rd_only = (paddr == DPFC_OFS_GENERAL_SWAPPED);
  assign gen_word = {gen_high, gen_low};

  always_comb begin
    mapped = 1'b1;
    rd_data = DPFC_WORD_ZERO;
    unique case (paddr)
      DPFC_OFS_FRAME_OFFSET: rd_data = {24'h000000, offs_q};
      DPFC_OFS_POINTER_CONTROL: rd_data = {27'h0000000, wbs_q, sel_q};
      DPFC_OFS_GENERAL_WORD: rd_data = {16'h0000, gen_word};
      DPFC_OFS_GENERAL_LOW_BYTE: rd_data = {24'h000000, gen_low};
      DPFC_OFS_GENERAL_HIGH_BYTE: rd_data = {24'h000000, gen_high};
      DPFC_OFS_GENERAL_SWAPPED: rd_data = {16'h0000, gen_low, gen_high};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_q <= DPFC_WORD_ZERO;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= (!pwrite && mapped) ? rd_data : DPFC_WORD_ZERO;
      pslverr_q <= !mapped || (pwrite && rd_only);
    end else if (access) begin
      prdata_q <= DPFC_WORD_ZERO;
      pslverr_q <= 1'b0;
    end
  end

  // ==========================================================
  // Frame offset with auto step
  always_comb begin
    offs_stepped = fp_decrement ? offs_q - DPFC_OFFS_STEP : offs_q + DPFC_OFFS_STEP;
    offs_d = offs_q;
    if (fp_access && fp_modify) begin
      offs_d = offs_stepped;
    end
    if (wr_offs) begin
      offs_d = pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      offs_q <= DPFC_RST_FRAME_OFFSET;
    end else begin
      offs_q <= offs_d;
    end
  end

  // ==========================================================
  // Frame pointer and access address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fp_q <= 16'h0000;
    end else begin
      fp_q <= 16'(frame_base + {DPFC_BYTE_ZERO, offs_d});
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fp_addr_q <= 16'h0000;
      fp_valid_q <= 1'b0;
    end else begin
      fp_valid_q <= fp_access;
      if (fp_access && fp_access_write && fp_modify) begin
        fp_addr_q <= 16'(frame_base + {DPFC_BYTE_ZERO, offs_stepped});
      end else if (fp_access) begin
        fp_addr_q <= 16'(frame_base + {DPFC_BYTE_ZERO, offs_q});
      end
    end
  end

  // ==========================================================
  // Pointer control
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wbs_q <= CTRL_RST[DPFC_WBS_MSB:DPFC_WBS_LSB];
    end else if (wr_ctrl) begin
      wbs_q <= pwdata[DPFC_WBS_MSB:DPFC_WBS_LSB];
    end
  end

  always_comb begin
    sel_d = sel_q;
    active_d = active_q;
    if (dp_zero_written) begin
      sel_d = DPFC_SEL_DP_ZERO;
      active_d = 1'b1;
    end else if (dp_one_written) begin
      sel_d = DPFC_SEL_DP_ONE;
      active_d = 1'b1;
    end else if (frame_base_written || wr_offs) begin
      sel_d = DPFC_SEL_FRAME;
      active_d = 1'b1;
    end else if (wr_ctrl) begin
      sel_d = pwdata[DPFC_SEL_MSB:DPFC_SEL_LSB];
      active_d = 1'b1;
    end
  end

  // Raw code is kept for readback, decoded select drives the output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_q <= CTRL_RST[DPFC_SEL_MSB:DPFC_SEL_LSB];
      src_q <= CTRL_RST[DPFC_SEL_MSB:DPFC_SEL_LSB];
      active_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      src_q <= (sel_d == DPFC_SEL_RESERVED) ? DPFC_SEL_FRAME : sel_d;
      active_q <= active_d;
    end
  end

  // ==========================================================
  // General word storage
  dpfc_byte_reg u_low (
    .clk(clk),
    .rst_n(rst_n),
    .we((wr_word && pstrb[0]) || wr_low),
    .wdata(pwdata[7:0]),
    .q(gen_low)
  );

  dpfc_byte_reg u_high (
    .clk(clk),
    .rst_n(rst_n),
    .we((wr_word && pstrb[1]) || wr_high),
    .wdata(wr_high ? pwdata[7:0] : pwdata[15:8]),
    .q(gen_high)
  );

  // ==========================================================
  // Outputs
  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign frame_pointer = fp_q;
  assign fp_access_addr = fp_addr_q;
  assign fp_access_valid = fp_valid_q;
  assign source_pointer_select = src_q;
  assign source_valid = active_q;
  assign word_byte_select_zero = wbs_q[0];
  assign word_byte_select_one = wbs_q[1];
  assign word_byte_select_frame = wbs_q[2];
  assign frame_offset = offs_q;

  // ==========================================================
  // Assertions
  a_ctrl_reset_value: assert property (@(posedge clk) $rose(rst_n) |->
    wbs_q == CTRL_RST[DPFC_WBS_MSB:DPFC_WBS_LSB])
    else $error("control word bits wrong after reset");

  a_read_post_step: assert property (@(posedge clk) disable iff (!rst_n)
    (fp_access && !fp_access_write && !wr_offs) |=>
    fp_addr_q == 16'($past(frame_base) + {DPFC_BYTE_ZERO, $past(offs_q)}))
    else $error("read address did not use old offset");

  a_write_pre_step: assert property (@(posedge clk) disable iff (!rst_n)
    (fp_access && fp_access_write && fp_modify && !wr_offs) |=>
    fp_addr_q == 16'($past(frame_base) + {DPFC_BYTE_ZERO, offs_q}))
    else $error("write address did not use stepped offset");

  a_offs_wrap_up: assert property (@(posedge clk) disable iff (!rst_n)
    (fp_access && fp_modify && !fp_decrement && !wr_offs && offs_q == 8'hFF) |=>
    offs_q == 8'h00)
    else $error("offset increment did not wrap");

  a_fp_sum_track: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(frame_base) && $stable(offs_q) |=>
    frame_pointer == 16'($past(frame_base) + {DPFC_BYTE_ZERO, offs_q}))
    else $error("frame pointer is not base plus offset");

  a_sel_dp_one: assert property (@(posedge clk) disable iff (!rst_n)
    (dp_one_written && !dp_zero_written) |=> source_pointer_select == DPFC_SEL_DP_ONE
    && source_valid)
    else $error("select did not follow pointer one write");

  a_src_inactive: assert property (@(posedge clk) disable iff (!rst_n)
    (!source_valid && !wr_ctrl && !wr_offs && !dp_zero_written && !dp_one_written
    && !frame_base_written) |=> !source_valid)
    else $error("source became active without a write");

  a_ctrl_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && paddr == DPFC_OFS_POINTER_CONTROL) |=> prdata[15:5] == 11'h000)
    else $error("reserved control bits read nonzero");

  a_swap_view: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && paddr == DPFC_OFS_GENERAL_SWAPPED) |=>
    prdata[15:0] == {$past(gen_low), $past(gen_high)})
    else $error("swapped view wrong");

  a_low_keeps_high: assert property (@(posedge clk) disable iff (!rst_n)
    wr_low |=> gen_high == $past(gen_high) && gen_low == $past(pwdata[7:0]))
    else $error("low byte write disturbed high byte");

  a_apb_answer: assert property (@(posedge clk) disable iff (!rst_n)
    setup |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  c_fp_read_step: cover property (@(posedge clk) disable iff (!rst_n)
    fp_access && fp_modify && !fp_access_write);
  c_fp_write_step: cover property (@(posedge clk) disable iff (!rst_n)
    fp_access && fp_modify && fp_access_write);
  c_ctrl_write: cover property (@(posedge clk) disable iff (!rst_n) wr_ctrl);
  c_slverr: cover property (@(posedge clk) disable iff (!rst_n) pslverr && pready);

endmodule : dpfc_top

// *** testbench/dpfc_core_model.sv ***
// Core-side model: frame base value, pointer write strobes, frame pointer accesses.
// Assumes the block samples every strobe at the rising edge of clk.
`timescale 1ns/10ps
module dpfc_core_model (
  input wire logic clk,
  input wire logic fp_access_valid,
  input wire logic [15:0] fp_access_addr,
  output logic [15:0] frame_base,
  output logic dp_zero_written,
  output logic dp_one_written,
  output logic frame_base_written,
  output logic fp_access,
  output logic fp_access_write,
  output logic fp_modify,
  output logic fp_decrement
);
  // ==========================================================
  // Core-side drivers
  initial begin
    {frame_base, dp_zero_written, dp_one_written, frame_base_written} = '0;
    {fp_access, fp_access_write, fp_modify, fp_decrement} = '0;
  end

  task automatic set_base(input logic [15:0] v);
    @(posedge clk);
    frame_base <= v;
  endtask : set_base

  // Callers select the frame pointer before any read through it
  task automatic access(input logic w, input logic m, input logic dec,
                        output logic v, output logic [15:0] a);
    @(posedge clk);
    fp_access <= 1'b1;
    fp_access_write <= w;
    fp_modify <= m;
    fp_decrement <= dec;
    @(posedge clk);
    fp_access <= 1'b0;
    fp_modify <= 1'b0;
    fp_access_write <= ~w;
    fp_decrement <= ~dec;
    @(posedge clk);
    v = fp_access_valid;
    a = fp_access_addr;
  endtask : access

  task automatic pulse(input logic [1:0] which);
    @(posedge clk);
    dp_zero_written <= (which == 2'h0);
    dp_one_written <= (which == 2'h1);
    frame_base_written <= (which == 2'h2);
    @(posedge clk);
    {dp_zero_written, dp_one_written, frame_base_written} <= 3'h0;
    @(posedge clk);
  endtask : pulse
endmodule : dpfc_core_model

// *** testbench/test_dpfc_top.sv ***
// Self-checking bench for the pointer control register block.
// Assumes the APB slave answers after setup and the core model drives the pointer side.
`timescale 1ns/10ps
module test_dpfc_top
  import dpfc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, dp0_w, dp1_w, base_w, acc, acc_w, modify, dec;
  logic [31:0] prdata;
  logic [15:0] base, fp, acc_addr;
  logic acc_valid, sel_valid, wb0, wb1, wb2;
  logic [2:0] wbw;
  logic [1:0] sel;
  logic [7:0] offs;
  int miscompares = 0;
  int compares = 0;

  always #12.5 clk = ~clk;

  dpfc_top #(.WORD_RESET_VARIANT(1'b0)) i_dpfc_top (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .frame_base(base),
    .dp_zero_written(dp0_w), .dp_one_written(dp1_w), .frame_base_written(base_w),
    .fp_access(acc), .fp_access_write(acc_w), .fp_modify(modify), .fp_decrement(dec),
    .frame_pointer(fp), .fp_access_addr(acc_addr), .fp_access_valid(acc_valid),
    .source_pointer_select(sel), .source_valid(sel_valid), .word_byte_select_zero(wb0),
    .word_byte_select_one(wb1), .word_byte_select_frame(wb2), .frame_offset(offs));

  dpfc_core_model i_dpfc_core_model (.clk(clk), .fp_access_valid(acc_valid),
    .fp_access_addr(acc_addr), .frame_base(base), .dp_zero_written(dp0_w),
    .dp_one_written(dp1_w), .frame_base_written(base_w), .fp_access(acc),
    .fp_access_write(acc_w), .fp_modify(modify), .fp_decrement(dec));

  // Second reset variant shares every input and only shows its mode bits
  dpfc_top #(.WORD_RESET_VARIANT(1'b1)) i_dpfc_top_word (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(), .prdata(), .pslverr(), .frame_base(base),
    .dp_zero_written(dp0_w), .dp_one_written(dp1_w), .frame_base_written(base_w),
    .fp_access(acc), .fp_access_write(acc_w), .fp_modify(modify), .fp_decrement(dec),
    .frame_pointer(), .fp_access_addr(), .fp_access_valid(), .source_pointer_select(),
    .source_valid(), .word_byte_select_zero(wbw[0]), .word_byte_select_one(wbw[1]),
    .word_byte_select_frame(wbw[2]), .frame_offset());

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk({e, r}, {1'b0, exp});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(e, err);
  endtask : wr

  task automatic fa(input logic w, input logic m, input logic dc, input logic [15:0] ea,
                    input logic [7:0] eo);
    logic v;
    logic [15:0] a;
    i_dpfc_core_model.access(w, m, dc, v, a);
    chk({v, a}, {1'b1, ea});
    chk(offs, eo);
  endtask : fa

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd(DPFC_OFS_FRAME_OFFSET, 32'h0000_0000);
    rd(DPFC_OFS_POINTER_CONTROL, {16'h0000, DPFC_RST_CTRL_BYTE_VARIANT});
    rd(DPFC_OFS_GENERAL_WORD, 32'h0000_0000);
    rd(DPFC_OFS_GENERAL_SWAPPED, 32'h0000_0000);
    chk(sel_valid, 1'b0);
    chk({wb2, wb1, wb0}, DPFC_RST_CTRL_BYTE_VARIANT[DPFC_WBS_MSB:DPFC_WBS_LSB]);
    chk(wbw, DPFC_RST_CTRL_WORD_VARIANT[DPFC_WBS_MSB:DPFC_WBS_LSB]);
    $display("reset test done");
  endtask : t_reset

  task automatic t_select;
    i_dpfc_core_model.pulse(2'h0);
    chk({sel_valid, sel}, {1'b1, DPFC_SEL_DP_ZERO});
    i_dpfc_core_model.pulse(2'h1);
    chk(sel, DPFC_SEL_DP_ONE);
    i_dpfc_core_model.pulse(2'h2);
    chk(sel, DPFC_SEL_FRAME);
    $display("select test done");
  endtask : t_select

  task automatic t_control;
    logic [1:0] c;
    logic [2:0] wb;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wb = {c[0], ~c[0], c[1]};
      wr(DPFC_OFS_POINTER_CONTROL, {16'hFFFF, 11'h7FF, wb, c}, 1'b0);
      rd(DPFC_OFS_POINTER_CONTROL, {27'h0, wb, c});
      chk(sel, (c == DPFC_SEL_RESERVED) ? DPFC_SEL_FRAME : c);
      chk({wb2, wb1, wb0}, wb);
    end
    $display("control test done");
  endtask : t_control

  task automatic t_general;
    wr(DPFC_OFS_GENERAL_WORD, 32'h0000_1234, 1'b0);
    wr(DPFC_OFS_GENERAL_LOW_BYTE, 32'h0000_00AB, 1'b0);
    wr(DPFC_OFS_GENERAL_HIGH_BYTE, 32'h0000_00CD, 1'b0);
    rd(DPFC_OFS_GENERAL_WORD, 32'h0000_CDAB);
    rd(DPFC_OFS_GENERAL_LOW_BYTE, 32'h0000_00AB);
    rd(DPFC_OFS_GENERAL_HIGH_BYTE, 32'h0000_00CD);
    wr(DPFC_OFS_GENERAL_SWAPPED, 32'h0000_5555, 1'b1);
    rd(DPFC_OFS_GENERAL_SWAPPED, 32'h0000_ABCD);
    wr(8'h40, 32'h0000_0001, 1'b1);
    $display("general test done");
  endtask : t_general

  task automatic t_frame;
    i_dpfc_core_model.set_base(16'hFFF0);
    wr(DPFC_OFS_FRAME_OFFSET, 32'h0000_00FE, 1'b0);
    repeat (2) @(posedge clk);
    chk({sel, fp}, {DPFC_SEL_FRAME, 16'h00EE});
    fa(1'b0, 1'b1, 1'b0, 16'h00EE, 8'hFF);
    fa(1'b0, 1'b1, 1'b0, 16'h00EF, 8'h00);
    repeat (2) @(posedge clk);
    chk(fp, 16'hFFF0);
    fa(1'b1, 1'b1, 1'b1, 16'h00EF, 8'hFF);
    fa(1'b0, 1'b0, 1'b0, 16'h00EF, 8'hFF);
    rd(DPFC_OFS_FRAME_OFFSET, 32'h0000_00FF);
    $display("frame test done");
  endtask : t_frame

  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_select;
    t_control;
    t_general;
    t_frame;
    report_and_stop;
  end

  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end
endmodule : test_dpfc_top
